// *** core/pcf_defs.svh ***
// Offsets, field positions, reset values and limits of the capability field bank.
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH
`define PCF_OFS_MSI_CTRL 8'h50
`define PCF_OFS_MSIX_CTRL 8'h68
`define PCF_OFS_MSIX_TBL 8'h6C
`define PCF_OFS_MSIX_PBA 8'h70
`define PCF_OFS_DEV_CAP 8'h84
`define PCF_OFS_LINK_CAP 8'h90
`define PCF_OFS_SLOT_CAP 8'h94
`define PCF_OFS_LINK_STS 8'h98
`define PCF_OFS_EVT_STS 8'h9C
`define PCF_CAPID_MSI 8'h05
`define PCF_CAPID_MSIX 8'h11
`define PCF_MSI_EN_BIT 16
`define PCF_MSI_MME_LSB 20
`define PCF_MSIX_EN_BIT 31
`define PCF_MSIX_MASK_BIT 30
`define PCF_SLOT_VAL_LSB 7
`define PCF_SLOT_SCL_LSB 15
`define PCF_LSTS_SCLK_BIT 28
`define PCF_LSTS_DLUP_BIT 29
`define PCF_EVT_SD_BIT 0
`define PCF_RST_SLOT_SCALE 2'b00
`define PCF_RST_MME 3'h0
`define PCF_BIR_MAX 3'h5
`endif

// *** core/pcf_pkg.sv ***
// Shared types of the capability field bank.
package pcf_pkg;
  typedef enum logic [2:0] {
    PCF_L0S_64NS = 3'h0, PCF_L0S_128NS = 3'h1, PCF_L0S_256NS = 3'h2,
    PCF_L0S_512NS = 3'h3, PCF_L0S_1US = 3'h4, PCF_L0S_2US = 3'h5,
    PCF_L0S_4US = 3'h6, PCF_L0S_NOLIM = 3'h7
  } pcf_l0s_lat_e;
  typedef enum logic [2:0] {
    PCF_L1_1US = 3'h0, PCF_L1_2US = 3'h1, PCF_L1_4US = 3'h2, PCF_L1_8US = 3'h3,
    PCF_L1_16US = 3'h4, PCF_L1_32US = 3'h5, PCF_L1_NOLIM = 3'h7
  } pcf_l1_lat_e;
  typedef enum logic [1:0] {
    PCF_SCALE_1 = 2'h0, PCF_SCALE_0P1 = 2'h1, PCF_SCALE_0P01 = 2'h2, PCF_SCALE_0P001 = 2'h3
  } pcf_pwr_scale_e;
  typedef struct packed {
    pcf_pwr_scale_e scale;
    logic [7:0] value;
  } pcf_slot_pwr_s;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } pcf_dph_s;
endpackage

// *** core/pcf_cap_fields.sv ***
// Capability field bank: configured read-only dwords plus a few live control fields.
`include "pcf_defs.svh"
module pcf_cap_fields #(
  parameter bit P_ROOT_PORT = 1'b0,
  parameter bit P_SURPRISE_DOWN = 1'b0,
  parameter bit P_DL_ACTIVE = 1'b0,
  parameter bit P_SLOT_CLOCK = 1'b1,
  parameter logic [7:0] P_PORT_NUM = 8'h01,
  parameter logic [3:0] P_MAX_SPEED = 4'h1,
  parameter logic [5:0] P_MAX_WIDTH = 6'h01,
  parameter logic [2:0] P_MAX_PAYLOAD = 3'h0,
  parameter int P_MSI_REQ = 1,
  parameter bit P_MSI_64 = 1'b1,
  parameter bit P_MSIX_EN = 1'b0,
  parameter logic [10:0] P_MSIX_TBL_SIZE = 11'h000,
  parameter logic [31:0] P_MSIX_TBL_OFS = 32'h0000_0000,
  parameter logic [2:0] P_MSIX_TBL_BIR = 3'h0,
  parameter logic [31:0] P_MSIX_PBA_OFS = 32'h0000_0000,
  parameter logic [2:0] P_MSIX_PBA_BIR = 3'h0,
  parameter bit P_SLOT_EN = 1'b0,
  parameter logic [12:0] P_SLOT_NUM = 13'h0000,
  parameter logic [6:0] P_SLOT_FLAGS = 7'h00,
  parameter bit P_NO_CMD_CPL = 1'b0,
  parameter logic [7:0] P_SLOT_PWR_VALUE = 8'h00,
  parameter pcf_pkg::pcf_l0s_lat_e P_L0S_LAT = pcf_pkg::PCF_L0S_64NS,
  parameter pcf_pkg::pcf_l1_lat_e P_L1_LAT = pcf_pkg::PCF_L1_1US
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link state and error reporting
  input wire logic dl_up,
  output logic surprise_down_err,
  output logic aspm_allowed,
  // Interrupt configuration seen by the application
  output logic msi_enable,
  output logic [2:0] msi_mme,
  output logic msix_enable,
  output logic msix_fn_mask,
  // Set_Slot_Power_Limit message request
  output pcf_pkg::pcf_slot_pwr_s slot_pwr_msg,
  output logic slot_pwr_msg_valid
);
  import pcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Configured constants.

  // Log2 of an MSI request count; counts other than powers of two up to 16 map to 0.
  function automatic logic [2:0] msi_log2(input int cnt);
    logic [2:0] res;
    res = 3'h0;
    case (cnt)
      2: res = 3'h1;
      4: res = 3'h2;
      8: res = 3'h3;
      16: res = 3'h4;
      default: res = 3'h0;
    endcase
    return res;
  endfunction

  // An indicator above the last BAR would send software to a register that does not exist.
  function automatic logic [2:0] legal_bir(input logic [2:0] bir);
    return (bir > `PCF_BIR_MAX) ? 3'h0 : bir;
  endfunction

  localparam logic [2:0] MMC = msi_log2(P_MSI_REQ);
  localparam bit MSIX_ON = P_MSIX_EN;
  localparam bit SLOT_ON = P_ROOT_PORT && P_SLOT_EN;
  localparam bit SD_ON = P_ROOT_PORT && P_SURPRISE_DOWN;
  localparam bit DLA_ON = P_ROOT_PORT && P_DL_ACTIVE;

  // Latency fields stay zero on a root port.
  localparam logic [2:0] L0S_CODE = P_ROOT_PORT ? 3'h0 : P_L0S_LAT;
  localparam logic [2:0] L1_CODE = P_ROOT_PORT ? 3'h0 : P_L1_LAT;
  localparam logic [31:0] DEV_CAP_WORD = {20'h0_0000, L1_CODE, L0S_CODE, 3'h0, P_MAX_PAYLOAD};

  // ASPM support bits stay zero since the core never enters L0s or L1.
  localparam logic [31:0] LINK_CAP_WORD = {P_PORT_NUM, 3'h0, DLA_ON, SD_ON,
                                           7'h00, 2'b00, P_MAX_WIDTH, P_MAX_SPEED};

  localparam logic [31:0] TBL_WORD = MSIX_ON ?
    {P_MSIX_TBL_OFS[31:3], legal_bir(P_MSIX_TBL_BIR)} : 32'h0000_0000;
  localparam logic [31:0] PBA_WORD = MSIX_ON ?
    {P_MSIX_PBA_OFS[31:3], legal_bir(P_MSIX_PBA_BIR)} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phases.

  logic aph_take;
  pcf_dph_s dph_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_word;

  assign aph_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // Only bits 7:0 are decoded, so the bank repeats every 256 bytes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= '0;
    end else if (hready) begin
      dph_ff.wr <= aph_take && hwrite;
      dph_ff.addr <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Live fields and their next values.

  logic msi_en_ff, nxt_msi_en;
  logic [2:0] mme_ff, nxt_mme;
  logic msix_en_ff, nxt_msix_en;
  logic msix_mask_ff, nxt_msix_mask;
  pcf_slot_pwr_s slot_pwr_ff, nxt_slot_pwr;
  logic slot_wr;
  logic dl_up_ff;
  logic sd_event;
  logic sd_sts_ff, nxt_sd_sts;
  logic sd_clr;
  logic [2:0] wr_mme;

  assign wr_mme = hwdata[`PCF_MSI_MME_LSB +: 3];
  assign sd_event = SD_ON && dl_up_ff && !dl_up;
  assign slot_wr = SLOT_ON && dph_ff.wr && (dph_ff.addr == `PCF_OFS_SLOT_CAP);
  assign sd_clr = dph_ff.wr && (dph_ff.addr == `PCF_OFS_EVT_STS) && hwdata[`PCF_EVT_SD_BIT];

  // Writes take effect at the end of the data phase; every other field but the surprise-down status ignores them.
  always_comb begin
    nxt_msi_en = msi_en_ff;
    nxt_mme = mme_ff;
    nxt_msix_en = msix_en_ff;
    nxt_msix_mask = msix_mask_ff;
    nxt_slot_pwr = slot_pwr_ff;
    if (dph_ff.wr) begin
      case (dph_ff.addr)
        `PCF_OFS_MSI_CTRL: begin
          nxt_msi_en = hwdata[`PCF_MSI_EN_BIT];
          nxt_mme = (wr_mme > MMC) ? MMC : wr_mme;
        end
        `PCF_OFS_MSIX_CTRL: begin
          nxt_msix_en = MSIX_ON && hwdata[`PCF_MSIX_EN_BIT];
          nxt_msix_mask = MSIX_ON && hwdata[`PCF_MSIX_MASK_BIT];
        end
        `PCF_OFS_SLOT_CAP: begin
          if (SLOT_ON) begin
            nxt_slot_pwr.value = hwdata[`PCF_SLOT_VAL_LSB +: 8];
            nxt_slot_pwr.scale = pcf_pwr_scale_e'(hwdata[`PCF_SLOT_SCL_LSB +: 2]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // A new surprise-down event wins over a clear in the same cycle.
  assign nxt_sd_sts = (sd_sts_ff && !sd_clr) || sd_event;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msi_en_ff <= 1'b0;
      mme_ff <= `PCF_RST_MME;
    end else begin
      msi_en_ff <= nxt_msi_en;
      mme_ff <= nxt_mme;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msix_en_ff <= 1'b0;
      msix_mask_ff <= 1'b0;
    end else begin
      msix_en_ff <= nxt_msix_en;
      msix_mask_ff <= nxt_msix_mask;
    end
  end

  // The scale is reset to 1.0x; the value starts at its configured default.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_pwr_ff.scale <= pcf_pwr_scale_e'(`PCF_RST_SLOT_SCALE);
      slot_pwr_ff.value <= P_SLOT_PWR_VALUE;
    end else begin
      slot_pwr_ff <= nxt_slot_pwr;
    end
  end

  // Every slot power write requests one message, even if the value is unchanged.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_pwr_msg_valid <= 1'b0;
      slot_pwr_msg <= '0;
    end else begin
      slot_pwr_msg_valid <= slot_wr;
      if (slot_wr) begin
        slot_pwr_msg <= nxt_slot_pwr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dl_up_ff <= 1'b0;
      surprise_down_err <= 1'b0;
      sd_sts_ff <= 1'b0;
    end else begin
      dl_up_ff <= dl_up;
      surprise_down_err <= sd_event;
      sd_sts_ff <= nxt_sd_sts;
    end
  end

  assign msi_enable = msi_en_ff;
  assign msi_mme = mme_ff;
  assign msix_enable = msix_en_ff;
  assign msix_fn_mask = msix_mask_ff;
  assign aspm_allowed = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Reads use the next values so a read right behind a write sees the written data.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      `PCF_OFS_MSI_CTRL: begin
        rd_word = {8'h00, 1'b0, nxt_mme, MMC, nxt_msi_en, 8'h00, `PCF_CAPID_MSI};
        rd_word[23] = P_MSI_64;
      end
      `PCF_OFS_MSIX_CTRL: begin
        if (MSIX_ON) begin
          rd_word = {nxt_msix_en, nxt_msix_mask, 3'h0, P_MSIX_TBL_SIZE,
                     8'h00, `PCF_CAPID_MSIX};
        end
      end
      `PCF_OFS_MSIX_TBL: rd_word = TBL_WORD;
      `PCF_OFS_MSIX_PBA: rd_word = PBA_WORD;
      `PCF_OFS_DEV_CAP: rd_word = DEV_CAP_WORD;
      `PCF_OFS_LINK_CAP: rd_word = LINK_CAP_WORD;
      `PCF_OFS_SLOT_CAP: begin
        if (SLOT_ON) begin
          rd_word = {P_SLOT_NUM, P_NO_CMD_CPL, 1'b0, nxt_slot_pwr.scale,
                     nxt_slot_pwr.value, P_SLOT_FLAGS};
        end
      end
      `PCF_OFS_LINK_STS: begin
        rd_word[`PCF_LSTS_SCLK_BIT] = P_SLOT_CLOCK;
        rd_word[`PCF_LSTS_DLUP_BIT] = DLA_ON && dl_up;
      end
      `PCF_OFS_EVT_STS: rd_word[`PCF_EVT_SD_BIT] = nxt_sd_sts;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (aph_take && !hwrite) begin
      hrdata_ff <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic rd_take;
  assign rd_take = aph_take && !hwrite;

  ro_link_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_LINK_CAP |=> hrdata == LINK_CAP_WORD
  ) else $error("link capabilities read differs from configuration");

  no_aspm_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_LINK_CAP |=> hrdata[11:10] == 2'b00
  ) else $error("link capabilities advertise low-power support");

  dev_lat_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_DEV_CAP |=> hrdata[8:6] == L0S_CODE
                                                 && hrdata[11:9] == L1_CODE
  ) else $error("latency fields wrong");

  slot_msg_pulse_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dph_ff.wr && dph_ff.addr == `PCF_OFS_SLOT_CAP && SLOT_ON
    |=> slot_pwr_msg_valid && slot_pwr_msg == $past(hwdata[16:7]) ##1 !slot_pwr_msg_valid
  ) else $error("slot power write gave no single message");

  slot_msg_cause_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    slot_pwr_msg_valid |-> SLOT_ON && $past(dph_ff.wr)
  ) else $error("slot power message without a slot power write");

  msix_absent_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !MSIX_ON |-> !msix_enable && !msix_fn_mask
  ) else $error("MSI-X active while not implemented");

  mme_limit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    msi_mme <= MMC
  ) else $error("MSI enabled count above capable count");

  sd_report_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    SD_ON && $fell(dl_up) |=> surprise_down_err ##1 !surprise_down_err
  ) else $error("surprise-down not reported as one pulse");

  sd_sticky_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sd_sts_ff && !sd_clr |=> sd_sts_ff
  ) else $error("surprise-down status lost without a clear");

  unmapped_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == 8'h00 |=> hrdata == 32'h0000_0000
  ) else $error("unmapped read not zero");

  msi_cap_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_MSI_CTRL |=> hrdata[19:17] == MMC
  ) else $error("MSI capable count read differs from configuration");

  msix_size_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_MSIX_CTRL && MSIX_ON |=> hrdata[26:16] == P_MSIX_TBL_SIZE
  ) else $error("MSI-X table size read differs from configuration");

  tbl_bir_legal_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_MSIX_TBL |=> hrdata[2:0] <= `PCF_BIR_MAX
  ) else $error("table BAR indicator out of range");

  pba_bir_legal_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_MSIX_PBA |=> hrdata[2:0] <= `PCF_BIR_MAX
  ) else $error("pending array BAR indicator out of range");

  slot_clock_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_LINK_STS |=> hrdata[`PCF_LSTS_SCLK_BIT] == P_SLOT_CLOCK
  ) else $error("slot clock indication differs from configuration");

  slot_num_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[7:0] == `PCF_OFS_SLOT_CAP && SLOT_ON |=> hrdata[31:19] == P_SLOT_NUM
  ) else $error("physical slot number read differs from configuration");

  slot_pwr_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !slot_wr |=> $stable(slot_pwr_ff)
  ) else $error("slot power limit changed without a slot power write");

  // Unused inputs of the bus: size is not checked since only word transfers occur.
  logic unused_bits;
  assign unused_bits = ^{haddr[31:8], hsize};
endmodule

// *** dv/pcf_host_model.sv ***
// Host configuration master model issuing single word AHB-Lite transfers.
module pcf_host_model (
  // Clock
  input wire logic hclk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end
  // Called right after a rising edge; returns at the edge that ends the data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    haddr <= ~a;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Released data lines never keep the last value, so stale reuse shows up.
    hwdata <= ~d;
  endtask
endmodule

// *** dv/pcf_cap_fields_tb.sv ***
// Self-checking bench for the capability field bank, root port with slot and MSI-X.
module pcf_cap_fields_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcf_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic dl_up = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, sde, aspm, msi_en, mx_en, mx_mask, pv;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, mme;
  pcf_slot_pwr_s pmsg;
  pcf_slot_pwr_s msgs [8];
  int mismatches = 0;
  int compares = 0;
  int pcnt = 0;
  int scnt = 0;
  localparam logic [10:0] TBL_SIZE = 11'h7FF;
  localparam logic [31:0] TBL_OFS = 32'h0000_2000;
  localparam logic [2:0] TBL_BIR = 3'h2;
  localparam logic [31:0] PBA_OFS = 32'h0000_3000;
  localparam logic [2:0] PBA_BIR = 3'h5;
  localparam logic [12:0] SLOT_NUM = 13'h1234;
  localparam logic [6:0] SLOT_FLAGS = 7'h55;
  localparam bit NO_CMD_CPL = 1'b1;
  localparam logic [7:0] PWR_VALUE = 8'h25;
  always #4 hclk = ~hclk;
  pcf_cap_fields #(.P_ROOT_PORT(1'b1), .P_SURPRISE_DOWN(1'b1), .P_MSI_REQ(4),
    .P_MSIX_EN(1'b1), .P_MSIX_TBL_SIZE(TBL_SIZE), .P_MSIX_TBL_OFS(TBL_OFS),
    .P_MSIX_TBL_BIR(TBL_BIR), .P_MSIX_PBA_OFS(PBA_OFS), .P_MSIX_PBA_BIR(PBA_BIR),
    .P_SLOT_EN(1'b1), .P_SLOT_NUM(SLOT_NUM), .P_SLOT_FLAGS(SLOT_FLAGS),
    .P_NO_CMD_CPL(NO_CMD_CPL), .P_SLOT_PWR_VALUE(PWR_VALUE)) pcf_cap_fields_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dl_up(dl_up),
    .surprise_down_err(sde), .aspm_allowed(aspm), .msi_enable(msi_en), .msi_mme(mme),
    .msix_enable(mx_en), .msix_fn_mask(mx_mask), .slot_pwr_msg(pmsg),
    .slot_pwr_msg_valid(pv));
  pcf_host_model pcf_host_model_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  always @(posedge hclk) begin
    if (pv === 1'b1) begin
      msgs[pcnt % 8] <= pmsg;
      pcnt <= pcnt + 1;
    end
    if (sde === 1'b1) begin
      scnt <= scnt + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    pcf_host_model_inst.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a);
    pcf_host_model_inst.xfer(1'b0, a, 32'h0000_0000, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rd(32'h0000_0050);
    chk({17'h0_0000, r[23:17], r[7:0]}, {17'h0_0000, 7'h42, 8'h05});
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    rd(32'h0000_0068);
    chk({13'h0000, r[26:16], r[7:0]}, {13'h0000, 11'h7FF, 8'h11});
    rd(32'h0000_006C);
    chk(r, 32'h0000_2002);
    rd(32'h0000_0070);
    chk(r, 32'h0000_3005);
    rd(32'h0000_0084);
    chk({29'h0000_0000, r[11:9]}, 32'h0000_0000);
    rd(32'h0000_0090);
    chk({r[31:24], 23'h00_0000, r[19]}, {8'h01, 23'h00_0000, 1'b1});
    rd(32'h0000_0094);
    chk(r, {13'h1234, 1'b1, 1'b0, 2'b00, 8'h25, 7'h55});
    rd(32'h0000_0098);
    chk({31'h0000_0000, r[28]}, 32'h0000_0001);
    rd(32'h0000_0040);
    chk(r, 32'h0000_0000);
    rd(32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, aspm}, 32'h0000_0000);
    $display("reset values done");
  endtask
  task automatic t_msi;
    wr(32'h0000_0050, 32'hFFFF_FFFF);
    rd(32'h0000_0050);
    chk({25'h000_0000, r[23:17]}, {25'h000_0000, 7'h52});
    chk({28'h000_0000, msi_en, mme}, 32'h0000_000A);
    wr(32'h0000_0068, 32'hFFFF_FFFF);
    rd(32'h0000_0068);
    chk({13'h0000, r[26:16], r[7:0]}, {13'h0000, 11'h7FF, 8'h11});
    chk({30'h0000_0000, mx_en, mx_mask}, 32'h0000_0003);
    wr(32'h0000_006C, 32'hFFFF_FFFF);
    rd(32'h0000_006C);
    chk(r, 32'h0000_2002);
    wr(32'h0000_0090, 32'h0000_0000);
    rd(32'h0000_0090);
    chk({31'h0000_0000, r[19]}, 32'h0000_0001);
    $display("msi and msix done");
  endtask
  // Writes one idle cycle apart at both value extremes, one per scale code.
  task automatic t_slot;
    int base;
    base = pcnt;
    for (int s = 0; s < 4; s++) begin
      wr(32'h0000_0094, {15'h0000, s[1:0], (s[0] ? 8'h00 : 8'hFF), 7'h00});
    end
    repeat (2) @(posedge hclk);
    chk(pcnt - base, 4);
    for (int s = 0; s < 4; s++) begin
      chk({22'h00_0000, msgs[(base + s) % 8]},
          {22'h00_0000, s[1:0], (s[0] ? 8'h00 : 8'hFF)});
    end
    rd(32'h0000_0094);
    chk(r, {13'h1234, 1'b1, 1'b0, 2'b11, 8'h00, 7'h55});
    $display("slot power done");
  endtask
  task automatic t_sdown;
    dl_up <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(scnt, 1);
    rd(32'h0000_009C);
    chk({31'h0000_0000, r[0]}, 32'h0000_0001);
    wr(32'h0000_009C, 32'h0000_0001);
    rd(32'h0000_009C);
    chk({31'h0000_0000, r[0]}, 32'h0000_0000);
    dl_up <= 1'b1;
    $display("surprise down done");
  endtask
  task automatic t_rereset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h0000_0094);
    chk({22'h00_0000, r[16:7]}, {22'h00_0000, 2'b00, 8'h25});
    chk({31'h0000_0000, msi_en}, 32'h0000_0000);
    $display("second reset done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_vals();
    t_msi();
    t_slot();
    t_sdown();
    t_rereset();
    wrap_up();
  end
  // The whole run needs under a hundred cycles; this margin only catches a hang.
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
endmodule
